// file: flash_ctl_pkg.sv
// Constants shared by the parallel flash controller
package flash_ctl_pkg;
   localparam int unsigned CLK_MHZ        = 125;
   // Bus cycle phase times, ns
   localparam int unsigned T_SETUP_NS     = 30;
   localparam int unsigned T_PULSE_NS     = 40;
   localparam int unsigned T_HOLD_NS      = 30;
   localparam int unsigned T_READ_NS      = 70;
   localparam int unsigned SETUP_CYC      = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PULSE_CYC      = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned HOLD_CYC       = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READ_CYC       = (T_READ_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W          = 4;
   // Command words and addresses (word mode, except ADDR_QUERY_B for byte mode)
   localparam logic [7:0]  CMD_UNLOCK1    = 8'hAA;
   localparam logic [7:0]  CMD_UNLOCK2    = 8'h55;
   localparam logic [7:0]  CMD_REGION_IN  = 8'h88;
   localparam logic [7:0]  CMD_REGION_OUT = 8'h90;
   localparam logic [7:0]  CMD_EXIT_DATA  = 8'h00;
   localparam logic [7:0]  CMD_QUERY      = 8'h98;
   localparam logic [7:0]  CMD_RESET      = 8'hF0;
   localparam logic [11:0] ADDR_UNLOCK1   = 12'h555;
   localparam logic [11:0] ADDR_UNLOCK2   = 12'h2AA;
   localparam logic [7:0]  ADDR_QUERY_W   = 8'h55;
   localparam logic [7:0]  ADDR_QUERY_B   = 8'hAA;
   // Secured region layout, word offsets
   localparam logic [3:0]  RANDOM_BASE    = 4'h0;
   localparam logic [3:0]  SERIAL_BASE    = 4'h8;
   localparam int unsigned REGION_WORDS   = 8;
   localparam int unsigned IND_BIT        = 7;
   // Boot sectors held by the write-protect pin
   localparam logic [7:0]  SEC_BOOT0      = 8'h00;
   localparam logic [7:0]  SEC_BOOT1      = 8'h01;
   localparam logic [7:0]  SEC_TOP0       = 8'h8C;
   localparam logic [7:0]  SEC_TOP1       = 8'h8D;
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_REGION_IN, OP_REGION_OUT, OP_QUERY, OP_RESET
   } op_t;
endpackage : flash_ctl_pkg

// file: flash_bus_cycle.sv
// One asynchronous flash bus cycle: setup, strobe, hold
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle #(
   parameter int unsigned AW = 22,
   parameter int unsigned DW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          reset,
   input  wire logic          start,
   input  wire logic          is_write,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [DW-1:0] dq_i,
   output logic               busy,
   output logic               done,
   output logic [DW-1:0]      rdata,
   output logic [AW-1:0]      a_o,
   output logic [DW-1:0]      dq_o,
   output logic               dq_oe,
   output logic               ce_n,
   output logic               we_n,
   output logic               oe_n
);
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;
   phase_t                            ph_r;
   logic [flash_ctl_pkg::CNT_W-1:0]   cnt_r;
   logic                              wr_r;

   assign busy = (ph_r != PH_IDLE);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ph_r  <= PH_IDLE;
         cnt_r <= '0;
         wr_r  <= 1'b0;
      end else begin
         case (ph_r)
            PH_IDLE: if (start) begin
               wr_r  <= is_write;
               ph_r  <= PH_SETUP;
               cnt_r <= flash_ctl_pkg::CNT_W'(flash_ctl_pkg::SETUP_CYC - 1);
            end
            PH_SETUP: if (cnt_r == '0) begin
               ph_r  <= PH_STROBE;
               cnt_r <= wr_r ? flash_ctl_pkg::CNT_W'(flash_ctl_pkg::PULSE_CYC - 1)
                             : flash_ctl_pkg::CNT_W'(flash_ctl_pkg::READ_CYC - 1);
            end else cnt_r <= cnt_r - 1'b1;
            PH_STROBE: if (cnt_r == '0) begin
               ph_r  <= PH_HOLD;
               cnt_r <= flash_ctl_pkg::CNT_W'(flash_ctl_pkg::HOLD_CYC - 1);
            end else cnt_r <= cnt_r - 1'b1;
            PH_HOLD: if (cnt_r == '0) ph_r <= PH_IDLE;
               else cnt_r <= cnt_r - 1'b1;
            default: ph_r <= PH_IDLE;
         endcase
      end
   end

   // Pins held in registers so strobes never glitch
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         a_o   <= '0;
         dq_o  <= '0;
         dq_oe <= 1'b0;
         ce_n  <= 1'b1;
         we_n  <= 1'b1;
         oe_n  <= 1'b1;
         rdata <= '0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (ph_r == PH_IDLE && start) begin
            a_o   <= addr;
            dq_o  <= wdata;
            dq_oe <= is_write;
            ce_n  <= 1'b0;
            oe_n  <= 1'b1;
         end
         // Write only with chip and write enable low and output enable high
         if (ph_r == PH_SETUP && cnt_r == '0) begin
            we_n <= ~wr_r;
            oe_n <= wr_r;
         end
         if (ph_r == PH_STROBE && cnt_r == '0) begin
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_r) rdata <= dq_i;
         end
         if (ph_r == PH_HOLD && cnt_r == '0) begin
            ce_n  <= 1'b1;
            dq_oe <= 1'b0;
            done  <= 1'b1;
         end
      end
   end
endmodule : flash_bus_cycle
`default_nettype wire

// file: flash_host_ctl.sv
// Host-side controller for a parallel NOR flash: modes, guards, sequences
//
// Overview of operation
// - Entry sequence maps secured region in
// - Lock by entry sequence then protect (this controller has no protect command)
// - Exit region before touching normal array (not checked here: array requests still pass while region_mapped is set)
// - Write only with CE, WE low, OE high
// - Query command 98h at 55h or AAh
// - Reset command leaves query mode
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctl #(
   parameter int unsigned AW = 22,
   parameter int unsigned DW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          reset,
   // User side
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire logic [2:0]    req_op,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   input  wire logic          req_boot_sector,
   input  wire logic          byte_mode,
   input  wire logic          supply_ok,
   input  wire logic          embedded_busy,
   input  wire logic          autoselect_mode,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   output logic               rsp_refused,
   output logic               region_mapped,
   output logic               query_mode,
   output logic               factory_locked,
   // Flash pins
   output logic [AW-1:0]      flash_addr,
   input  wire logic [DW-1:0] flash_dq_i,
   output logic [DW-1:0]      flash_dq_o,
   output logic               flash_dq_oe,
   output logic               flash_ce_n,
   output logic               flash_we_n,
   output logic               flash_oe_n,
   input  wire logic          write_protect_accel_pin
);
   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_WAIT, S_RESP} st_t;
   st_t              st_r;
   logic [1:0]       step_r;
   logic [1:0]       last_r;
   flash_ctl_pkg::op_t op_r;
   logic [AW-1:0]    addr_r;
   logic [DW-1:0]    data_r;
   logic             refuse_r;
   logic             powered_r;
   logic             cyc_start;
   logic             cyc_busy;
   logic             cyc_done;
   logic [DW-1:0]    cyc_rdata;
   logic             cyc_wr;
   logic [AW-1:0]    cyc_addr;
   logic [DW-1:0]    cyc_wdata;
   logic             refuse_nxt;

   // Refusal decided at request time
   always_comb begin
      refuse_nxt = 1'b0;
      // Brown-out and power-up: hold off every write
      if (!supply_ok || !powered_r)
         refuse_nxt = (req_op != flash_ctl_pkg::OP_READ);
      // Boot block stays locked as one unit while the pin is low and the region is not mapped
      if (req_op == flash_ctl_pkg::OP_WRITE && req_boot_sector && !write_protect_accel_pin
          && !region_mapped)
         refuse_nxt = 1'b1;
      // Region never written while its caught factory lock bit is set
      if (req_op == flash_ctl_pkg::OP_WRITE && region_mapped && factory_locked)
         refuse_nxt = 1'b1;
      // No query while embedded algorithm runs
      if (req_op == flash_ctl_pkg::OP_QUERY && embedded_busy)
         refuse_nxt = 1'b1;
   end

   assign req_ready = (st_r == S_IDLE);

   // Command word per step; sequences are issued as unlock, unlock, command
   // Full unlocks for region entry and exit only; write, query and reset go out as one bare cycle
   always_comb begin
      cyc_wr    = 1'b1;
      cyc_addr  = AW'(flash_ctl_pkg::ADDR_UNLOCK1);
      cyc_wdata = DW'(flash_ctl_pkg::CMD_UNLOCK1);
      case (op_r)
         flash_ctl_pkg::OP_READ: begin
            cyc_wr   = 1'b0;
            cyc_addr = addr_r;
         end
         flash_ctl_pkg::OP_WRITE: begin
            cyc_addr  = addr_r;
            cyc_wdata = data_r;
         end
         flash_ctl_pkg::OP_QUERY: begin
            // Query from read or autoselect alike
            cyc_addr  = byte_mode ? AW'(flash_ctl_pkg::ADDR_QUERY_B)
                                  : AW'(flash_ctl_pkg::ADDR_QUERY_W);
            cyc_wdata = DW'(flash_ctl_pkg::CMD_QUERY);
         end
         flash_ctl_pkg::OP_RESET: cyc_wdata = DW'(flash_ctl_pkg::CMD_RESET);
         default: begin
            // Three-cycle region entry or exit
            if (step_r == 2'd1) begin
               cyc_addr  = AW'(flash_ctl_pkg::ADDR_UNLOCK2);
               cyc_wdata = DW'(flash_ctl_pkg::CMD_UNLOCK2);
            end else if (step_r == 2'd2) begin
               cyc_wdata = (op_r == flash_ctl_pkg::OP_REGION_IN)
                           ? DW'(flash_ctl_pkg::CMD_REGION_IN)
                           : DW'(flash_ctl_pkg::CMD_REGION_OUT);
            end
         end
      endcase
   end

   assign cyc_start = (st_r == S_SEQ);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r     <= S_IDLE;
         step_r   <= 2'd0;
         last_r   <= 2'd0;
         op_r     <= flash_ctl_pkg::OP_READ;
         addr_r   <= '0;
         data_r   <= '0;
         refuse_r <= 1'b0;
      end else begin
         case (st_r)
            S_IDLE: if (req_valid) begin
               op_r     <= flash_ctl_pkg::op_t'(req_op);
               addr_r   <= req_addr;
               data_r   <= req_wdata;
               refuse_r <= refuse_nxt;
               step_r   <= 2'd0;
               last_r   <= (req_op == flash_ctl_pkg::OP_REGION_IN ||
                            req_op == flash_ctl_pkg::OP_REGION_OUT) ? 2'd2 : 2'd0;
               st_r     <= refuse_nxt ? S_RESP : S_SEQ;
            end
            S_SEQ: st_r <= S_WAIT;
            S_WAIT: if (cyc_done) begin
               if (step_r == last_r) st_r <= S_RESP;
               else begin
                  step_r <= step_r + 2'd1;
                  st_r   <= S_SEQ;
               end
            end
            S_RESP: st_r <= S_IDLE;
            default: st_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rsp_valid   <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_rdata   <= '0;
      end else begin
         rsp_valid   <= (st_r == S_RESP);
         rsp_refused <= (st_r == S_RESP) && refuse_r;
         if (st_r == S_WAIT && cyc_done && op_r == flash_ctl_pkg::OP_READ)
            rsp_rdata <= cyc_rdata;
      end
   end

   // Mirror of device mode; reset and brown-out drop to array read
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         region_mapped <= 1'b0;
         query_mode    <= 1'b0;
         powered_r     <= 1'b0;
      end else begin
         powered_r <= supply_ok;
         if (!supply_ok) begin
            region_mapped <= 1'b0;
            query_mode    <= 1'b0;
         end else if (st_r == S_RESP && !refuse_r) begin
            case (op_r)
               flash_ctl_pkg::OP_REGION_IN:  region_mapped <= 1'b1;
               flash_ctl_pkg::OP_REGION_OUT: region_mapped <= 1'b0;
               flash_ctl_pkg::OP_QUERY:      query_mode    <= 1'b1;
               flash_ctl_pkg::OP_RESET:      query_mode    <= 1'b0;
               default: ;
            endcase
         end
      end
   end

   // Indicator bit caught from each read of the mapped region taken with autoselect_mode high
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) factory_locked <= 1'b0;
      else if (st_r == S_WAIT && cyc_done && op_r == flash_ctl_pkg::OP_READ
               && region_mapped && autoselect_mode)
         factory_locked <= cyc_rdata[flash_ctl_pkg::IND_BIT];
   end

   flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (cyc_start),
      .is_write (cyc_wr),
      .addr     (cyc_addr),
      .wdata    (cyc_wdata),
      .dq_i     (flash_dq_i),
      .busy     (cyc_busy),
      .done     (cyc_done),
      .rdata    (cyc_rdata),
      .a_o      (flash_addr),
      .dq_o     (flash_dq_o),
      .dq_oe    (flash_dq_oe),
      .ce_n     (flash_ce_n),
      .we_n     (flash_we_n),
      .oe_n     (flash_oe_n)
   );

   a_write_strobe: assert property (@(posedge core_clk) disable iff (reset)
      !flash_we_n |-> (!flash_ce_n && flash_oe_n))
      else $error("write strobe without chip enable or with output enable");
   a_cycle_idle: assert property (@(posedge core_clk) disable iff (reset)
      cyc_start |-> !cyc_busy)
      else $error("bus cycle started while another still runs");
   a_boot_guard: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_IDLE && req_valid && req_op == flash_ctl_pkg::OP_WRITE && req_boot_sector
       && !write_protect_accel_pin && !region_mapped) |=> refuse_r)
      else $error("boot sector write not refused with pin low");
   a_lowsupply_exit: assert property (@(posedge core_clk) disable iff (reset)
      !supply_ok |=> (!region_mapped && !query_mode))
      else $error("mode kept under low supply");
   a_query_busy: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_IDLE && req_valid && req_op == flash_ctl_pkg::OP_QUERY && embedded_busy)
      |=> (st_r == S_RESP) ##1 (rsp_refused && !query_mode))
      else $error("query issued during embedded operation");
   a_refused_quiet: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_RESP && refuse_r) |-> flash_we_n)
      else $error("refused request drove a write");
   a_region_enter: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_RESP && !refuse_r && op_r == flash_ctl_pkg::OP_REGION_IN && supply_ok)
      |=> region_mapped)
      else $error("region not mapped after entry sequence");
   a_reset_leaves: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_RESP && !refuse_r && op_r == flash_ctl_pkg::OP_RESET) |=> !query_mode)
      else $error("query mode kept after reset command");
   a_powerup_hold: assert property (@(posedge core_clk) disable iff (reset)
      (st_r == S_IDLE && req_valid && !powered_r && req_op != flash_ctl_pkg::OP_READ)
      |=> refuse_r)
      else $error("command accepted at power-up");
   c_serial_read: cover property (@(posedge core_clk) disable iff (reset)
      cyc_done && region_mapped && op_r == flash_ctl_pkg::OP_READ
      && addr_r[3:0] >= flash_ctl_pkg::SERIAL_BASE);
   c_region_in: cover property (@(posedge core_clk) disable iff (reset) $rose(region_mapped));
   c_query: cover property (@(posedge core_clk) disable iff (reset) $rose(query_mode));
   c_refused: cover property (@(posedge core_clk) disable iff (reset) rsp_refused);
endmodule : flash_host_ctl
`default_nettype wire

// file: flash_dev_model.sv
// Behavioural parallel flash device facing the host controller
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
   parameter int unsigned AW      = 22,
   parameter int unsigned DW      = 16,
   parameter bit          FACTORY = 1'b1
) (
   input  wire logic          rst,
   input  wire logic          supply_ok,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] dq_host,
   input  wire logic          ce_n,
   input  wire logic          we_n,
   input  wire logic          oe_n,
   output logic [DW-1:0]      dq_dev
);
   logic [1:0]    unlock_r = 2'h0;
   logic          region_r = 1'b0;
   logic          query_r = 1'b0;
   logic [DW-1:0] last_r = '0;
   logic [DW-1:0] word;
   // Commands land on the rising write strobe; the region has no write path at all
   always @(posedge we_n or posedge rst or negedge supply_ok) begin
      if (rst || !supply_ok) begin
         unlock_r <= 2'h0;
         region_r <= 1'b0;
         query_r  <= 1'b0;
      end else if (!ce_n && oe_n) begin
         if (dq_host[7:0] == 8'hF0) begin
            query_r  <= 1'b0;
            unlock_r <= 2'h0;
         end else if (dq_host[7:0] == 8'h98 && addr[7:0] inside {8'h55, 8'hAA}) begin
            query_r <= 1'b1;
         end else if (unlock_r == 2'h0 && dq_host[7:0] == 8'hAA && addr[11:0] == 12'h555) begin
            unlock_r <= 2'h1;
         end else if (unlock_r == 2'h1 && dq_host[7:0] == 8'h55 && addr[11:0] == 12'h2AA) begin
            unlock_r <= 2'h2;
         end else if (unlock_r == 2'h2 && addr[11:0] == 12'h555) begin
            if (dq_host[7:0] == 8'h88) region_r <= 1'b1;
            if (dq_host[7:0] == 8'h90) region_r <= 1'b0;
            unlock_r <= 2'h0;
         end else begin
            unlock_r <= 2'h0;
         end
      end
   end
   always_comb begin
      if (query_r) word = 16'h0051;
      else if (region_r) word = {4'h5, addr[3:0], FACTORY, 3'h0, addr[3:0]};
      else word = {addr[7:0], ~addr[7:0]};
   end
   // A released bus shows the inverse of the last word, never a stale copy
   always @(posedge oe_n) last_r <= word;
   assign dq_dev = (!ce_n && !oe_n) ? word : ~last_r;
endmodule : flash_dev_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the host flash controller with a device model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int unsigned AW = 22;
   localparam int unsigned DW = 16;
   logic          core_clk = 1'b0;
   logic          reset = 1'b1;
   logic          req_valid = 1'b0;
   logic          req_ready;
   logic [2:0]    req_op = 3'h0;
   logic [AW-1:0] req_addr = '0;
   logic [DW-1:0] req_wdata = '0;
   logic          req_boot_sector = 1'b0;
   logic          byte_mode = 1'b0;
   logic          supply_ok = 1'b1;
   logic          embedded_busy = 1'b0;
   logic          autoselect_mode = 1'b0;
   logic          write_protect_accel_pin = 1'b1;
   logic          rsp_valid, rsp_refused, region_mapped, query_mode, factory_locked;
   logic [DW-1:0] rsp_rdata, flash_dq_o, dq_dev, got;
   logic [AW-1:0] flash_addr;
   logic          flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, refd;
   wire  [DW-1:0] dq_bus = flash_dq_oe ? flash_dq_o : dq_dev;
   int            mismatches = 0;
   int            n_tests = 0;
   int            n_ce = 0;
   int            moved = 0;
   always #4 core_clk = ~core_clk;
   always @(negedge flash_ce_n) n_ce++;
   flash_host_ctl #(.AW(AW), .DW(DW)) dut (.core_clk(core_clk), .reset(reset),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_boot_sector(req_boot_sector), .byte_mode(byte_mode),
      .supply_ok(supply_ok), .embedded_busy(embedded_busy),
      .autoselect_mode(autoselect_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_refused(rsp_refused), .region_mapped(region_mapped), .query_mode(query_mode),
      .factory_locked(factory_locked), .flash_addr(flash_addr), .flash_dq_i(dq_bus),
      .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
      .write_protect_accel_pin(write_protect_accel_pin));
   flash_dev_model #(.AW(AW), .DW(DW), .FACTORY(1'b1)) dev (.rst(reset),
      .supply_ok(supply_ok), .addr(flash_addr), .dq_host(dq_bus), .ce_n(flash_ce_n),
      .we_n(flash_we_n), .oe_n(flash_oe_n), .dq_dev(dq_dev));
   task automatic stop_test;
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rq(input logic [2:0] op, input logic [AW-1:0] a, input logic [DW-1:0] d,
                     input logic boot);
      int i;
      int n0;
      n0 = n_ce;
      i = 0;
      while (req_ready !== 1'b1 && i < 100) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      // A request that is never taken also runs the response wait out below
      if (i == 100) begin
         mismatches++;
         $display("BAD t=%0t not ready got=%h exp=%h", $time, 1'b0, 1'b1);
      end
      @(posedge core_clk);
      req_valid       <= 1'b1;
      req_op          <= op;
      req_addr        <= a;
      req_wdata       <= d;
      req_boot_sector <= boot;
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1;
      i = 0;
      while (rsp_valid !== 1'b1 && i < 500) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      if (i == 500) begin
         mismatches++;
         $display("BAD t=%0t no response got=%h exp=%h", $time, 1'b0, 1'b1);
         stop_test();
      end else begin
         got   = rsp_rdata;
         refd  = rsp_refused;
         moved = n_ce - n0;
      end
   endtask : rq
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk(16'({flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe}), 16'h000E);
      chk(16'({region_mapped, query_mode, factory_locked}), 16'h0000);
      repeat (3) @(posedge core_clk);
      rq(flash_ctl_pkg::OP_READ, 22'h000123, 16'h0000, 1'b0);
      chk(got, 16'h23DC);
      rq(flash_ctl_pkg::OP_WRITE, 22'h000200, 16'h1234, 1'b0);
      chk(16'({refd, moved[3:0]}), 16'h0001);
      $display("Test array access done");
      for (int v = 0; v < 2; v++) begin
         @(posedge core_clk) write_protect_accel_pin <= v[0];
         rq(flash_ctl_pkg::OP_WRITE, 22'h000000, 16'hABCD, 1'b1);
         chk(16'({refd, moved[3:0]}), v ? 16'h0001 : 16'h0010);
      end
      @(posedge core_clk) supply_ok <= 1'b0;
      rq(flash_ctl_pkg::OP_WRITE, 22'h000200, 16'h5678, 1'b0);
      chk(16'({refd, moved[3:0]}), 16'h0010);
      @(posedge core_clk) supply_ok <= 1'b1;
      $display("Test write guards done");
      @(posedge core_clk) embedded_busy <= 1'b1;
      rq(flash_ctl_pkg::OP_QUERY, 22'h000000, 16'h0000, 1'b0);
      chk(16'({refd, query_mode}), 16'h0002);
      @(posedge core_clk) embedded_busy <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk) byte_mode <= i[0];
         autoselect_mode <= i[0];
         rq(flash_ctl_pkg::OP_QUERY, 22'h000000, 16'h0000, 1'b0);
         chk(16'({refd, query_mode}), 16'h0001);
         @(posedge core_clk) byte_mode <= 1'b0;
         autoselect_mode <= 1'b0;
         rq(flash_ctl_pkg::OP_READ, 22'h000010, 16'h0000, 1'b0);
         chk(got, 16'h0051);
         rq(flash_ctl_pkg::OP_RESET, 22'h000000, 16'h0000, 1'b0);
         rq(flash_ctl_pkg::OP_READ, 22'h000010, 16'h0000, 1'b0);
         chk(16'({query_mode, got[7:0]}), 16'h00EF);
      end
      $display("Test query mode done");
      rq(flash_ctl_pkg::OP_REGION_IN, 22'h000000, 16'h0000, 1'b0);
      chk(16'(region_mapped), 16'h0001);
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk) autoselect_mode <= (k == 0);
         rq(flash_ctl_pkg::OP_READ, AW'(k), 16'h0000, 1'b0);
         chk(got, {4'h5, k[3:0], 1'b1, 3'h0, k[3:0]});
      end
      @(posedge core_clk) autoselect_mode <= 1'b0;
      chk(16'(factory_locked), 16'h0001);
      rq(flash_ctl_pkg::OP_WRITE, 22'h000003, 16'h0000, 1'b0);
      chk(16'({refd, moved[3:0], region_mapped}), 16'h0021);
      rq(flash_ctl_pkg::OP_REGION_OUT, 22'h000000, 16'h0000, 1'b0);
      rq(flash_ctl_pkg::OP_READ, 22'h000005, 16'h0000, 1'b0);
      chk(16'({region_mapped, got}), 16'h05FA);
      rq(flash_ctl_pkg::OP_REGION_IN, 22'h000000, 16'h0000, 1'b0);
      @(posedge core_clk) supply_ok <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk(16'(region_mapped), 16'h0000);
      @(posedge core_clk) supply_ok <= 1'b1;
      rq(flash_ctl_pkg::OP_REGION_IN, 22'h000000, 16'h0000, 1'b0);
      @(posedge core_clk) reset <= 1'b1;
      repeat (9) @(posedge core_clk);
      // Request meets the first edge after release, before supply has been seen
      fork
         rq(flash_ctl_pkg::OP_REGION_IN, 22'h000000, 16'h0000, 1'b0);
         @(posedge core_clk) reset <= 1'b0;
      join
      chk(16'({refd, moved[3:0], region_mapped}), 16'h0020);
      rq(flash_ctl_pkg::OP_READ, 22'h000003, 16'h0000, 1'b0);
      chk(16'({region_mapped, got}), 16'h03FC);
      $display("Test secured region done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
